// ### logic/bpc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module bpc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Streams
    bpc_stream_if.sink in_s,
    bpc_stream_if.source out_s
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("bpc_fifo: DEPTH must be a power of two of at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
        logic not_full;
        logic not_empty;
    } bpc_fifo_s;

    bpc_fifo_s st;
    bpc_fifo_s next_st;
    logic push;
    logic pop;

    // Ready and valid come from flops so the handshake outputs stay registered
    assign in_s.ready = st.not_full;
    assign out_s.valid = st.not_empty;
    assign out_s.data = st.mem[st.rp];

    always_comb begin
        next_st = st;
        push = in_s.valid && st.not_full;
        pop = st.not_empty && out_s.ready;
        if (push) begin
            next_st.mem[st.wp] = in_s.data;
            next_st.wp = st.wp + PW'(1);
        end
        if (pop) begin
            next_st.rp = st.rp + PW'(1);
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + CW'(1);
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - CW'(1);
        end
        next_st.not_full = (next_st.cnt != CW'(DEPTH));
        next_st.not_empty = (next_st.cnt != CW'(0));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{mem: '0, wp: '0, rp: '0, cnt: '0, not_full: 1'b1, not_empty: 1'b0};
        end else begin
            st <= next_st;
        end
    end
endmodule : bpc_fifo
`default_nettype wire

// ### logic/bpc_pkg.sv
package bpc_pkg;
    // Register offsets (byte addresses on the serial register port)
    localparam logic [7:0] OFS_FRONTEND = 8'h08;
    localparam logic [7:0] OFS_CONVERTER = 8'h10;
    localparam logic [7:0] OFS_INT_CTRL = 8'h4c;
    localparam logic [7:0] OFS_INT_FLAGS = 8'h54;
    localparam logic [7:0] OFS_DIG_ENABLES = 8'h60;
    localparam logic [7:0] OFS_DIG_CTRL = 8'h64;
    localparam logic [7:0] OFS_BUF_CTRL = 8'hc0;
    localparam logic [7:0] OFS_BUF_WR_WORD = 8'hc4;
    localparam logic [7:0] OFS_BUF_RD_WORD = 8'hc8;
    localparam logic [7:0] OFS_BUF_THRESH = 8'hcc;

    // Reset values
    localparam logic [31:0] RST_FRONTEND = 32'h010ad443;
    localparam logic [31:0] RST_CONVERTER = 32'h002f5555;
    localparam logic [31:0] RST_INT_CTRL = 32'h00000000;
    localparam logic [31:0] RST_DIG_ENABLES = 32'h00000000;
    localparam logic [31:0] RST_DIG_CTRL = 32'h0000000b;
    localparam logic [31:0] RST_BUF_CTRL = 32'h00000000;

    // Field positions
    localparam int ZIN_HI = 15;
    localparam int ZIN_LO = 14;
    localparam int TWO_E_BIT = 10;
    localparam int GAIN_HI = 7;
    localparam int GAIN_LO = 4;
    localparam int PD_BIT = 0;
    localparam int CRATE_HI = 20;
    localparam int CRATE_LO = 18;
    localparam int POL_BIT = 15;
    localparam int FLAG_HI = 12;
    localparam int FLAG_LO = 1;
    localparam int CLR_HI = 28;
    localparam int CLR_LO = 17;
    localparam int START_HI = 5;
    localparam int START_LO = 3;
    localparam int DRATE_HI = 2;
    localparam int DRATE_LO = 0;
    localparam int CS_BIT = 31;
    localparam int STEP_BIT = 30;
    localparam int TRIG_BIT = 29;
    localparam int WFLAG_BIT = 27;
    localparam int RFLAG_BIT = 26;
    localparam int PTR_HI = 25;
    localparam int PTR_LO = 16;
    localparam int ADDR_HI = 9;
    localparam int ADDR_LO = 0;
    localparam int TH_HI = 8;
    localparam int TH_LO = 0;

    // Defined enable bits: 10, 8..2, 0
    localparam logic [10:0] DIG_EN_MASK = 11'h5fd;
    localparam int DIG_EN_BUF_BIT = 4;
    localparam int DIG_EN_CKT_BIT = 3;

    // Impedance code forced outside two-electrode mode
    localparam logic [1:0] ZIN_IDLE = 2'h3;
    // Region size selected by the start point field
    localparam int START_SHIFT = 7;
    localparam int FIFO_DEPTH = 4;
endpackage : bpc_pkg

// ### logic/bpc_regs.sv
// Operation
// [RQ1] Status register bits 1..12 hold threshold, full, empty flags for four buffers.
// [RQ2] Impedance field 15:14 picks 500M, 250M or 125M; applies only in two-electrode mode.
// [RQ3] Bit 10 selects two-electrode mode when 1, right-leg-drive when 0.
// [RQ4] Gain field 7:4 codes 0..6 give gains 1..12; resets to code 4.
// [RQ5] Front-end power-down bit 0 powers down when 1; resets to 1.
// [RQ6] Converter rate field 20:18 picks 64, 128, 256 Hz, or 512 and above.
// [RQ7] Digital rate field 2:0 picks 64 to 4096 Hz; resets to code 3.
// [RQ8] Host keeps converter and digital rate codes matching when changing either.
// [RQ9] Converter power-down bit 0 powers down when 1; resets to 1.
// [RQ10] Start point field 5:3 sets where cardiac storage starts; resets to 1.
// [RQ11] Bit 31 is the cardiac memory chip select for host access; resets 0.
// [RQ12] Bit 30 set makes the host access address step after each access.
// [RQ13] Writing 1 to bit 29 toggles the access trigger; writing 0 does nothing.
// [RQ14] Bits 27 and 26 show a host write or read trigger was issued.
// [RQ15] Bits 25:16 report the address currently used for host access.
// [RQ16] Bits 9:0 hold the host access address, writable, reset to zero.
// [RQ17] Register 0xC4 holds the word a host write stores in the buffer.
// [RQ18] Register 0xC8 shows the word fetched by a host read.
// [RQ19] Threshold register bits 25:16 report the data path's current buffer address.
// [RQ20] Threshold register bits 8:0 set the fill level raising the threshold event.
// [RQ21] Digital enable register resets to zero; each defined bit enables one block.
// [RQ22] Host clears a flag: enable to 0, clear bit to 1, then clear bit to 0.
// [RQ23] Polarity bit 15 of interrupt control inverts the interrupt output.
// [RQ24] Each buffer raises threshold, full and empty conditions.
// [RQ25] A flag sets on its condition while enabled and holds until cleared.
// [RQ26] The host access address wraps to zero past the top location.
`timescale 1ns/1ps
`default_nettype none
module bpc_regs #(
    parameter int BUF_WORDS = 1024,
    parameter int FIFO_WORDS = bpc_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port from the serial front end
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Converter sample stream
    input wire logic sample_valid,
    input wire logic [31:0] sample_data,
    output logic sample_ready,
    // Conditions of the other buffers {beat, optical two, optical one} x {empty, full, thr}
    input wire logic [8:0] other_buffer_events,
    // Analog and block controls
    output logic [1:0] input_impedance_select,
    output logic electrode_scheme_select,
    output logic [3:0] amplifier_gain_code,
    output logic frontend_powerdown,
    output logic [2:0] converter_rate_code,
    output logic converter_powerdown,
    output logic [2:0] digital_rate_code,
    output logic [2:0] buffer_start_point,
    output logic [10:0] digital_block_enables,
    // Interrupt
    output logic irq_out
);
    generate
        if (BUF_WORDS != 1024) begin : g_bad_words
            $error("bpc_regs: pointer fields are 10 bits, BUF_WORDS must be 1024");
        end
    endgenerate

    typedef struct packed {
        logic [1:0] zin;
        logic two_e;
        logic [3:0] gain;
        logic fe_pd;
        logic [2:0] conv_rate;
        logic conv_pd;
        logic int_pol;
        logic [11:0] int_en;
        logic [11:0] int_clr;
        logic [11:0] flags;
        logic [10:0] dig_en;
        logic [2:0] start_pt;
        logic [2:0] dig_rate;
        logic cs;
        logic autostep;
        logic trig_tgl;
        logic wr_flag;
        logic rd_flag;
        logic [9:0] cur_ptr;
        logic [9:0] acc_ptr;
        logic [31:0] wr_word;
        logic [31:0] rd_word;
        logic wr_pending;
        logic [9:0] dp_ptr;
        logic [8:0] thresh;
        logic [10:0] fill;
        logic buf_on_q;
        logic [31:0] rdata;
        logic rvalid;
        logic irq;
        logic [1:0] zin_eff;
    } bpc_state_s;

    bpc_state_s st;
    bpc_state_s next_st;
    logic [1:0] rst_sync;
    logic rst_sync_b;
    logic [31:0] mem [0:BUF_WORDS-1];
    logic mem_we;
    logic [9:0] mem_wa;
    logic [31:0] mem_wd;
    logic dp_ready;
    logic dp_take;
    logic host_trig;
    logic host_wr;
    logic host_rd;
    logic [9:0] addr_src;
    logic [2:0] card_cond;
    logic [11:0] cond;
    logic [10:0] fill_full;

    bpc_stream_if #(.WIDTH(32)) in_if ();
    bpc_stream_if #(.WIDTH(32)) out_if ();

    assign in_if.valid = sample_valid;
    assign in_if.data = sample_data;
    assign sample_ready = in_if.ready;
    assign out_if.ready = dp_ready;

    bpc_fifo #(.WIDTH(32), .DEPTH(FIFO_WORDS)) u_fifo (
        .clk(mclk),
        .rst_n(rst_sync_b),
        .in_s(in_if.sink),
        .out_s(out_if.source)
    );

    // Reset release through two flops; assertion is immediate
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_sync[1];

    assign fill_full = 11'(BUF_WORDS);
    assign card_cond[0] = (st.fill >= {2'h0, st.thresh});  // see RQ24
    assign card_cond[1] = (st.fill == fill_full);  // see RQ24
    assign card_cond[2] = (st.fill == 11'h0);  // see RQ24
    assign cond = {other_buffer_events, card_cond};  // see RQ1

    always_comb begin
        next_st = st;
        host_trig = reg_wr && (reg_addr == bpc_pkg::OFS_BUF_CTRL)
            && reg_wdata[bpc_pkg::TRIG_BIT];
        // A new address field takes effect in the same write that triggers
        addr_src = (reg_wdata[9:0] != st.acc_ptr) ? reg_wdata[9:0] : st.cur_ptr;
        host_wr = host_trig && reg_wdata[bpc_pkg::CS_BIT] && st.wr_pending;  // see RQ11
        host_rd = host_trig && reg_wdata[bpc_pkg::CS_BIT] && !st.wr_pending;  // see RQ11
        // Host write owns the single memory port; the sample path waits
        dp_ready = st.dig_en[bpc_pkg::DIG_EN_BUF_BIT] && st.dig_en[bpc_pkg::DIG_EN_CKT_BIT]
            && st.buf_on_q && !card_cond[1] && !host_wr;
        dp_take = dp_ready && out_if.valid;
        mem_we = host_wr || dp_take;
        mem_wa = host_wr ? addr_src : st.dp_ptr;
        mem_wd = host_wr ? st.wr_word : out_if.data;

        if (reg_wr) begin
            case (reg_addr)
                bpc_pkg::OFS_FRONTEND: begin
                    next_st.zin = reg_wdata[bpc_pkg::ZIN_HI:bpc_pkg::ZIN_LO];  // see RQ2
                    next_st.two_e = reg_wdata[bpc_pkg::TWO_E_BIT];  // see RQ3
                    next_st.gain = reg_wdata[bpc_pkg::GAIN_HI:bpc_pkg::GAIN_LO];  // see RQ4
                    next_st.fe_pd = reg_wdata[bpc_pkg::PD_BIT];  // see RQ5
                end
                bpc_pkg::OFS_CONVERTER: begin
                    next_st.conv_rate = reg_wdata[bpc_pkg::CRATE_HI:bpc_pkg::CRATE_LO];  // see RQ6
                    next_st.conv_pd = reg_wdata[bpc_pkg::PD_BIT];  // see RQ9
                end
                bpc_pkg::OFS_INT_CTRL: begin
                    next_st.int_pol = reg_wdata[bpc_pkg::POL_BIT];
                    next_st.int_en = reg_wdata[bpc_pkg::FLAG_HI:bpc_pkg::FLAG_LO];
                end
                bpc_pkg::OFS_INT_FLAGS: begin
                    next_st.int_clr = reg_wdata[bpc_pkg::CLR_HI:bpc_pkg::CLR_LO];
                end
                bpc_pkg::OFS_DIG_ENABLES: begin
                    next_st.dig_en = reg_wdata[10:0] & bpc_pkg::DIG_EN_MASK;  // see RQ21
                end
                bpc_pkg::OFS_DIG_CTRL: begin
                    next_st.start_pt = reg_wdata[bpc_pkg::START_HI:bpc_pkg::START_LO];  // see RQ10
                    next_st.dig_rate = reg_wdata[bpc_pkg::DRATE_HI:bpc_pkg::DRATE_LO];  // see RQ7
                end
                bpc_pkg::OFS_BUF_CTRL: begin
                    next_st.cs = reg_wdata[bpc_pkg::CS_BIT];
                    next_st.autostep = reg_wdata[bpc_pkg::STEP_BIT];
                    next_st.acc_ptr = reg_wdata[bpc_pkg::ADDR_HI:bpc_pkg::ADDR_LO];  // see RQ16
                    next_st.cur_ptr = addr_src;
                end
                bpc_pkg::OFS_BUF_WR_WORD: begin
                    next_st.wr_word = reg_wdata;  // see RQ17
                    next_st.wr_pending = 1'b1;
                end
                bpc_pkg::OFS_BUF_THRESH: begin
                    next_st.thresh = reg_wdata[bpc_pkg::TH_HI:bpc_pkg::TH_LO];  // see RQ20
                end
                default: begin
                end
            endcase
        end

        if (host_trig) begin
            next_st.trig_tgl = ~st.trig_tgl;  // see RQ13
        end
        if (host_wr) begin
            next_st.wr_flag = 1'b1;  // see RQ14
            next_st.rd_flag = 1'b0;
            next_st.wr_pending = 1'b0;
        end
        if (host_rd) begin
            next_st.rd_word = mem[addr_src];  // see RQ18
            next_st.rd_flag = 1'b1;  // see RQ14
            next_st.wr_flag = 1'b0;
        end
        if ((host_wr || host_rd) && reg_wdata[bpc_pkg::STEP_BIT]) begin
            next_st.cur_ptr = addr_src + 10'h1;  // see RQ12, see RQ26
        end

        // Fill level: samples in, host reads out
        if (dp_take && !(host_rd && st.fill != 11'h0)) begin
            next_st.fill = st.fill + 11'h1;
        end else if (!dp_take && host_rd && st.fill != 11'h0) begin
            next_st.fill = st.fill - 11'h1;
        end
        if (dp_take) begin
            next_st.dp_ptr = st.dp_ptr + 10'h1;  // see RQ19
        end
        // Storage restarts at the start point each time the buffer is switched on
        next_st.buf_on_q = st.dig_en[bpc_pkg::DIG_EN_BUF_BIT];
        if (st.dig_en[bpc_pkg::DIG_EN_BUF_BIT] && !st.buf_on_q) begin
            next_st.dp_ptr = 10'({st.start_pt, 7'h0});  // see RQ10
            next_st.fill = 11'h0;
        end

        // Clear needs enable low; a set in the same cycle still wins
        for (int i = 0; i < 12; i++) begin
            if (st.int_clr[i] && !st.int_en[i]) begin
                next_st.flags[i] = 1'b0;  // see RQ22
            end
            if (cond[i] && st.int_en[i]) begin
                next_st.flags[i] = 1'b1;  // see RQ25
            end
        end
        next_st.irq = (|st.flags) ^ st.int_pol;  // see RQ23
        next_st.zin_eff = st.two_e ? st.zin : bpc_pkg::ZIN_IDLE;  // see RQ2

        next_st.rvalid = reg_rd;
        next_st.rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                bpc_pkg::OFS_FRONTEND: begin
                    next_st.rdata[bpc_pkg::ZIN_HI:bpc_pkg::ZIN_LO] = st.zin;
                    next_st.rdata[bpc_pkg::TWO_E_BIT] = st.two_e;
                    next_st.rdata[bpc_pkg::GAIN_HI:bpc_pkg::GAIN_LO] = st.gain;
                    next_st.rdata[bpc_pkg::PD_BIT] = st.fe_pd;
                end
                bpc_pkg::OFS_CONVERTER: begin
                    next_st.rdata[bpc_pkg::CRATE_HI:bpc_pkg::CRATE_LO] = st.conv_rate;
                    next_st.rdata[bpc_pkg::PD_BIT] = st.conv_pd;
                end
                bpc_pkg::OFS_INT_CTRL: begin
                    next_st.rdata[bpc_pkg::POL_BIT] = st.int_pol;
                    next_st.rdata[bpc_pkg::FLAG_HI:bpc_pkg::FLAG_LO] = st.int_en;
                end
                bpc_pkg::OFS_INT_FLAGS: begin
                    next_st.rdata[bpc_pkg::CLR_HI:bpc_pkg::CLR_LO] = st.int_clr;
                    next_st.rdata[bpc_pkg::FLAG_HI:bpc_pkg::FLAG_LO] = st.flags;  // see RQ1
                end
                bpc_pkg::OFS_DIG_ENABLES: begin
                    next_st.rdata[10:0] = st.dig_en;
                end
                bpc_pkg::OFS_DIG_CTRL: begin
                    next_st.rdata[bpc_pkg::START_HI:bpc_pkg::START_LO] = st.start_pt;
                    next_st.rdata[bpc_pkg::DRATE_HI:bpc_pkg::DRATE_LO] = st.dig_rate;
                end
                bpc_pkg::OFS_BUF_CTRL: begin
                    next_st.rdata[bpc_pkg::CS_BIT] = st.cs;
                    next_st.rdata[bpc_pkg::STEP_BIT] = st.autostep;
                    next_st.rdata[bpc_pkg::TRIG_BIT] = st.trig_tgl;
                    next_st.rdata[bpc_pkg::WFLAG_BIT] = st.wr_flag;
                    next_st.rdata[bpc_pkg::RFLAG_BIT] = st.rd_flag;
                    next_st.rdata[bpc_pkg::PTR_HI:bpc_pkg::PTR_LO] = st.cur_ptr;  // see RQ15
                    next_st.rdata[bpc_pkg::ADDR_HI:bpc_pkg::ADDR_LO] = st.acc_ptr;
                end
                bpc_pkg::OFS_BUF_WR_WORD: begin
                    next_st.rdata = st.wr_word;
                end
                bpc_pkg::OFS_BUF_RD_WORD: begin
                    next_st.rdata = st.rd_word;
                end
                bpc_pkg::OFS_BUF_THRESH: begin
                    next_st.rdata[bpc_pkg::PTR_HI:bpc_pkg::PTR_LO] = st.dp_ptr;  // see RQ19
                    next_st.rdata[bpc_pkg::TH_HI:bpc_pkg::TH_LO] = st.thresh;
                end
                default: begin
                    next_st.rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st <= '0;
            st.zin <= bpc_pkg::RST_FRONTEND[bpc_pkg::ZIN_HI:bpc_pkg::ZIN_LO];
            st.two_e <= bpc_pkg::RST_FRONTEND[bpc_pkg::TWO_E_BIT];
            st.gain <= bpc_pkg::RST_FRONTEND[bpc_pkg::GAIN_HI:bpc_pkg::GAIN_LO];  // see RQ4
            st.fe_pd <= bpc_pkg::RST_FRONTEND[bpc_pkg::PD_BIT];  // see RQ5
            st.conv_rate <= bpc_pkg::RST_CONVERTER[bpc_pkg::CRATE_HI:bpc_pkg::CRATE_LO];
            st.conv_pd <= bpc_pkg::RST_CONVERTER[bpc_pkg::PD_BIT];  // see RQ9
            st.dig_en <= bpc_pkg::RST_DIG_ENABLES[10:0];  // see RQ21
            st.start_pt <= bpc_pkg::RST_DIG_CTRL[bpc_pkg::START_HI:bpc_pkg::START_LO];
            st.dig_rate <= bpc_pkg::RST_DIG_CTRL[bpc_pkg::DRATE_HI:bpc_pkg::DRATE_LO];
            st.zin_eff <= bpc_pkg::RST_FRONTEND[bpc_pkg::ZIN_HI:bpc_pkg::ZIN_LO];
        end else begin
            st <= next_st;
        end
    end

    // Buffer storage, no reset
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign input_impedance_select = st.zin_eff;
    assign electrode_scheme_select = st.two_e;
    assign amplifier_gain_code = st.gain;
    assign frontend_powerdown = st.fe_pd;
    assign converter_rate_code = st.conv_rate;
    assign converter_powerdown = st.conv_pd;
    assign digital_rate_code = st.dig_rate;
    assign buffer_start_point = st.start_pt;
    assign digital_block_enables = st.dig_en;
    assign irq_out = st.irq;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_sync_b);

    a_reset_values: assert property ($rose(rst_sync_b) |-> frontend_powerdown  // see RQ4
        && converter_powerdown && amplifier_gain_code == 4'h4 && digital_rate_code == 3'h3
        && buffer_start_point == 3'h1 && digital_block_enables == 11'h0)
        else $error("reset values wrong");
    a_flag_sets: assert property (st.int_en[0] && card_cond[0] |=> st.flags[0])  // see RQ25
        else $error("threshold flag not set");
    a_flag_holds: assert property (st.flags[0] && !(st.int_clr[0] && !st.int_en[0])  // see RQ22
        |=> st.flags[0])
        else $error("threshold flag lost");
    a_irq_polarity: assert property (st.flags == 12'h0 && st.int_pol  // see RQ23
        ##1 st.flags == 12'h0 && st.int_pol |=> irq_out)
        else $error("polarity not applied");
    a_zin_applied: assert property (st.two_e && st.zin == 2'h0  // see RQ2
        |=> input_impedance_select == 2'h0)
        else $error("impedance not applied in two-electrode mode");
    a_addr_step: assert property ((host_wr || host_rd) && reg_wdata[bpc_pkg::STEP_BIT]  // see RQ12
        |=> st.cur_ptr == $past(addr_src) + 10'h1)
        else $error("address did not step");
    a_addr_still: assert property ((host_wr || host_rd) && !reg_wdata[bpc_pkg::STEP_BIT]  // see RQ12
        |=> st.cur_ptr == $past(addr_src))
        else $error("address moved without autostep");
    a_trig_zero: assert property (reg_wr && reg_addr == bpc_pkg::OFS_BUF_CTRL  // see RQ13
        && !reg_wdata[bpc_pkg::TRIG_BIT] |=> st.trig_tgl == $past(st.trig_tgl))
        else $error("trigger toggled on zero");
    a_read_flag: assert property (host_rd |=> st.rd_flag && !st.wr_flag)  // see RQ14
        else $error("read trigger flag missing");
    a_full_stall: assert property (card_cond[1] |-> !dp_ready)  // see RQ24
        else $error("sample written into full buffer");
    a_rd_answer: assert property (reg_rd |=> reg_rvalid ##1 !$past(reg_rd) || reg_rvalid)
        else $error("register read not answered");

    c_flag_set: cover property (st.int_en[1] && card_cond[1] ##1 st.flags[1]);
    c_host_write: cover property (host_wr ##1 st.wr_flag);
    c_host_read: cover property (host_rd ##1 st.rd_flag);
    c_backpressure: cover property (sample_valid && !sample_ready);
endmodule : bpc_regs
`default_nettype wire

// ### logic/bpc_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bpc_stream_if #(parameter int WIDTH = 32);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : bpc_stream_if
`default_nettype wire

// ### tb/bpc_sample_src.sv
`timescale 1ns/1ps
`default_nettype none
module bpc_sample_src (
    input wire logic mclk,
    input wire logic [3:0] num,
    input wire logic sample_ready,
    output logic sample_valid,
    output logic [31:0] sample_data
);
    int sent = 0;
    initial sample_valid = 0;
    initial sample_data = 0;
    // Idle data flips so a stale word never passes for a fresh one
    always @(posedge mclk) begin
        if (sample_valid && sample_ready) sent = sent + 1;
        sample_valid <= sent < num;
        sample_data <= sent < num ? 32'ha5000000 + sent : ~sample_data;
    end
endmodule : bpc_sample_src
`default_nettype wire

// ### tb/test_bpc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_bpc_regs;
    logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, sample_data;
    logic [8:0] other_buffer_events = 0;
    logic [3:0] num = 0, amplifier_gain_code;
    logic [2:0] converter_rate_code, digital_rate_code, buffer_start_point;
    logic [1:0] input_impedance_select;
    logic [10:0] digital_block_enables;
    logic reg_rvalid, sample_valid, sample_ready, electrode_scheme_select;
    logic frontend_powerdown, converter_powerdown, irq_out;
    bit [31:0] cfg [256];
    bit [31:0] mem [1024];
    bit [31:0] msk [bit [7:0]] = '{8'h08: 32'hc4f1, 8'h10: 32'h1c0001, 8'h4c: 32'h9ffe,
        8'h60: 32'h5fd, 8'h64: 32'h3f, 8'hc0: 32'hc0000000, 8'hc4: 32'hffffffff,
        8'hcc: 32'h1ff, default: 0};
    bit [7:0] offs [11] = '{8'h08, 8'h10, 8'h4c, 8'h54, 8'h60, 8'h64, 8'hc0, 8'hc4, 8'hc8,
        8'hcc, 8'h3c};
    int fails = 0, num_checks = 0, ptr = 0, fld = 0, tg = 0, wf = 0, rf = 0, pend = 0;
    int rdw = 0, dp = 0, s, k;
    always #5 mclk = ~mclk;
    bpc_regs dut_u (.mclk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .sample_valid, .sample_data, .sample_ready, .other_buffer_events,
        .input_impedance_select, .electrode_scheme_select, .amplifier_gain_code,
        .frontend_powerdown, .converter_rate_code, .converter_powerdown,
        .digital_rate_code, .buffer_start_point, .digital_block_enables, .irq_out);
    bpc_sample_src src_u (.mclk, .num, .sample_ready, .sample_valid, .sample_data);
    task automatic chk(input string n, input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    function automatic bit [31:0] ex(input bit [7:0] a);
        if (a == 8'hc0) return cfg[a] | tg << 29 | wf << 27 | rf << 26 | ptr << 16 | fld;
        if (a == 8'hc8) return rdw;
        return a == 8'hcc ? cfg[a] | dp << 16 : cfg[a];
    endfunction : ex
    task automatic wr(input bit [7:0] a, input bit [31:0] d);
        int u;
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        cfg[a] = d & msk[a];
        if (a == 8'hc4) pend = 1;
        if (a == 8'hc0) ptr = d[9:0] != fld ? d[9:0] : ptr;
        if (a == 8'hc0 && d[31] && d[29]) begin
            u = ptr;
            wf = pend;
            rf = !pend;
            if (pend) mem[u] = cfg[8'hc4];
            else rdw = mem[u];
            pend = 0;
            ptr = d[30] ? (u + 1) % 1024 : u;
        end
        if (a == 8'hc0) tg ^= d[29];
        if (a == 8'hc0) fld = d[9:0];
        @(negedge mclk);
        reg_wr = 0;
    endtask : wr
    task automatic rd(input bit [7:0] a);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1;
        @(negedge mclk);
        reg_rd = 0;
        chk("rvalid", reg_rvalid, 1);
        chk("rdata", reg_rdata, ex(a));
    endtask : rd
    task automatic outs;
        chk("zin", input_impedance_select, cfg[8][10] ? cfg[8][15:14] : 2'h3);
        chk("scheme", electrode_scheme_select, cfg[8][10]);
        chk("gain", amplifier_gain_code, cfg[8][7:4]);
        chk("fepd", frontend_powerdown, cfg[8][0]);
        chk("crate", converter_rate_code, cfg[16][20:18]);
        chk("cpd", converter_powerdown, cfg[16][0]);
        chk("drate", digital_rate_code, cfg[100][2:0]);
        chk("start", buffer_start_point, cfg[100][5:3]);
        chk("en", digital_block_enables, cfg[96][10:0]);
    endtask : outs
    initial begin
        #300us;
        fails++;
        stop_test;
    end
    initial begin
        cfg[8] = 32'hc441;
        cfg[16] = 32'hc0001;
        cfg[100] = 32'hb;
        void'($urandom(94));
        repeat (16) @(negedge mclk);
        rst_b = 1;
        repeat (3) @(negedge mclk);
        outs;
        wr(8'hc8, 32'hffffffff);
        foreach (offs[i]) rd(offs[i]);
        $display("reset test done");
        repeat (4) begin
            s = $urandom;
            k = s[30:0] % 7;
            wr(8'h08, s & 32'hffff0f0f | k << 4);
            wr(8'h10, (k > 3 ? 3 : k) << 18 | s[0]);
            wr(8'h64, s & 32'h38 | k);
            wr(8'h60, s & 32'h7e7);
            @(negedge mclk);
            outs;
            foreach (offs[i]) rd(offs[i]);
        end
        $display("config test done");
        wr(8'hc4, 32'h1234abcd);
        wr(8'hc0, 32'ha0000003);
        rd(8'hc0);
        wr(8'hc0, 32'ha0000003);
        rd(8'hc0);
        rd(8'hc8);
        wr(8'hc4, 32'h0badf00d);
        wr(8'hc0, 32'he00003ff);
        wr(8'hc0, 32'h200003ff);
        rd(8'hc0);
        wr(8'hc0, 0);
        wr(8'hc0, 32'ha00003ff);
        rd(8'hc8);
        $display("buffer test done");
        num = 5;
        repeat (10) @(negedge mclk);
        chk("ready", sample_ready, 0);
        dp = cfg[100][5:3] * 128;
        wr(8'hcc, 3);
        wr(8'h60, 32'h18);
        repeat (10) @(negedge mclk);
        for (k = 0; k < 5; k++) mem[dp + k] = 32'ha5000000 + k;
        dp += 5;
        rd(8'hcc);
        wr(8'hc0, 32'ha0000000 | (dp - 5));
        rd(8'hc8);
        other_buffer_events = $urandom;
        wr(8'h4c, 32'h1ff2);
        cfg[8'h54] = other_buffer_events << 4 | 2;
        rd(8'h54);
        other_buffer_events = 0;
        chk("irq", irq_out, 1);
        wr(8'h4c, 0);
        wr(8'h54, 32'h1ffe0000);
        wr(8'h54, 0);
        rd(8'h54);
        chk("irq", irq_out, 0);
        wr(8'h4c, 32'h8000);
        rd(8'h4c);
        chk("irq", irq_out, 1);
        $display("stream and irq test done");
        stop_test;
    end
endmodule : test_bpc_regs
`default_nettype wire
